// file: bench/cpu_model.sv
// CPU core model taking and returning from interrupts
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bench controls
  input wire logic ackGo,
  input wire logic [3:0] ackWait,
  input wire logic retGo,
  input wire intc_pkg::level_type retLevel,
  // Controller side
  input wire logic irqRequest,
  output logic cpuAck,
  output logic cpuReturn,
  output intc_pkg::level_type returnLevel
);
  import intc_pkg::*;
  logic armed_reg;
  logic [3:0] wait_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      armed_reg <= 1'b0;
      wait_reg <= 4'h0;
      cpuAck <= 1'b0;
    end else begin
      cpuAck <= 1'b0;
      if (ackGo) armed_reg <= 1'b1;
      if (armed_reg && irqRequest) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == ackWait) begin
          cpuAck <= 1'b1;
          armed_reg <= 1'b0;
          wait_reg <= 4'h0;
        end
      end
    end
  end
  // level restore, level scrambled when idle
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpuReturn <= 1'b0;
      returnLevel <= 4'h0;
    end else begin
      cpuReturn <= retGo;
      returnLevel <= retGo ? retLevel : ~returnLevel;
    end
  end
endmodule : cpu_model

// file: bench/intc_monitor.sv
// Port checks of the interrupt controller
`timescale 1ns/1ps
`include "intc_defs.svh"
module intc_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire intc_pkg::axi_addr_type awaddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire intc_pkg::axi_addr_type araddr,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  // CPU side
  input wire logic cpuAck,
  input wire logic irqRequest,
  input wire intc_pkg::vector_type irqVector,
  input wire intc_pkg::level_type irqLevel,
  input wire logic useAltTable,
  input wire logic nestingOff
);
  import intc_pkg::*;
  axi_addr_type wrAddr_reg;
  axi_addr_type rdAddr_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Response owed to an address
  function automatic logic [1:0] resp_of(input axi_addr_type a);
    return (a[1:0] == 2'b00 && a <= `OFS_CORE_CONTROL) ? 2'b00 : 2'b10;
  endfunction : resp_of
  // Addresses of the last write and read
  always_ff @(posedge mclk) begin
    if (awvalid && awready) wrAddr_reg <= awaddr;
    if (arvalid && arready) rdAddr_reg <= araddr;
  end
  // ******
  // Checks
  // ******
  sequence s_taken;
    cpuAck && irqRequest;
  endsequence
  property p_raise;
    level_type lv;
    (s_taken ##0 (!nestingOff, lv = irqLevel)) |-> ##3 (!irqRequest || irqLevel > lv);
  endproperty
  a_reset_clear: assert property ($fell(reset) |-> !irqRequest && !bvalid && !rvalid
    && !nestingOff && !useAltTable && irqVector == 7'h00) else $error("outputs not clear");
  a_nest_on_write: assert property ($changed(nestingOff) |-> $rose(bvalid))
    else $error("nesting flag moved without a write");
  a_alt_on_write: assert property ($changed(useAltTable) |-> $rose(bvalid))
    else $error("table select moved without a write");
  a_trap_level: assert property (irqRequest && irqVector < 7'd8 |->
    irqVector inside {[1:4]} && irqLevel == 4'd15 - irqVector[3:0]) else $error("trap level");
  a_user_level: assert property (irqRequest && irqVector >= 7'd8 |->
    irqVector <= 7'd39 && !irqLevel[3] && irqLevel != 4'h0) else $error("user level");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_resp: assert property ($rose(rvalid) |-> rresp == resp_of(rdAddr_reg))
    else $error("read response code");
  a_write_resp: assert property ($rose(bvalid) |-> bresp == resp_of(wrAddr_reg))
    else $error("write response code");
  a_ack_raises: assert property (p_raise)
    else $error("level not raised by acknowledge");
  a_nest_blocks: assert property ((s_taken ##0 (nestingOff && !irqLevel[3])) |->
    ##3 (!irqRequest || irqLevel[3])) else $error("user source passed nesting block");
endmodule : intc_monitor
bind vectored_priority_interrupt_ctrl intc_monitor mon (.*);

// file: bench/tb_vectored_priority_interrupt_ctrl.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "intc_defs.svh"
module tb_vectored_priority_interrupt_ctrl;
  import intc_pkg::*;
  logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, arready, bvalid, rvalid, irqRequest, useAltTable, nestingOff;
  logic cpuAck, cpuReturn, ackGo = 0, retGo = 0;
  axi_addr_type awaddr = 0, araddr = 0;
  axi_data_type wdata = 0, rdata;
  logic [3:0] wstrb = 4'h3, ackWait = 0;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] sourcePulse = 0, seed = 32'h5ef0f72b, en, fl;
  logic [2:0] extPins = 0, cl;
  logic [4:0] trapPulse = 0;
  level_type returnLevel, irqLevel, retLevel = 0;
  vector_type irqVector;
  logic [2:0] pr [32];
  logic [11:0] ex;
  word_type rd;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  vectored_priority_interrupt_ctrl DUT (.*);
  cpu_model partner (.*);
  // ******
  // Helpers
  // ******
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Winner as {request, vector, level}
  function automatic logic [11:0] win();
    logic [3:0] b;
    logic [6:0] v;
    b = {1'b0, cl};
    v = 7'h00;
    for (int k = 0; k < 32; k++)
      if (fl[k] && en[k] && {1'b0, pr[k]} > b) begin
        b = {1'b0, pr[k]};
        v = 7'(k + 8);
      end
    return {v != 7'h00, v, b};
  endfunction : win
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic wr(input axi_addr_type a, input word_type d);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr
  task automatic rc(input axi_addr_type a, input word_type exp);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    rd = rdata[15:0];
    rs = rresp;
    chk(rd, exp);
  endtask : rc
  task automatic pulse(input logic [31:0] s, input logic [4:0] t);
    @(posedge mclk);
    sourcePulse <= s;
    trapPulse <= t;
    @(posedge mclk);
    sourcePulse <= 32'h0;
    trapPulse <= 5'h0;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task automatic cpu(input logic a, input level_type l);
    @(posedge mclk);
    ackGo <= a;
    retGo <= !a;
    retLevel <= l;
    @(posedge mclk);
    ackGo <= 1'b0;
    retGo <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask : cpu
  task automatic clr;
    wr(`OFS_FLAG_BASE, 16'h0);
    wr(`OFS_FLAG_BASE + 8'h04, 16'h0);
  endtask : clr
  task automatic pins(input logic [2:0] p);
    @(posedge mclk);
    extPins <= p;
    repeat (10) @(posedge mclk);
  endtask : pins
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end
  // ******
  // Main sequence
  // ******
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int a = 0; a <= 8'h44; a += 4) begin
      rc(8'(a), 16'h0);
      chk(rs, (a == 8'h44) ? 2'b10 : 2'b00);
    end
    wr(8'h44, 16'hffff);
    chk(rs, 2'b10);
    wr(`OFS_GLOBAL_CTRL_ONE, 16'h8000);
    chk(nestingOff, 1'b1);
    wr(`OFS_CPU_STATUS, 16'h00e0);
    rc(`OFS_CPU_STATUS, 16'h0);
    wr(`OFS_GLOBAL_CTRL_ONE, 16'h0);
    wr(`OFS_CPU_STATUS, 16'h00e0);
    rc(`OFS_CPU_STATUS, 16'h00e0);
    wr(`OFS_CORE_CONTROL, 16'h0008);
    rc(`OFS_CORE_CONTROL, 16'h0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      en = (i == 0) ? '1 : seed;
      seed = lfsr(seed);
      fl = seed;
      seed = lfsr(seed);
      cl = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : seed[2:0];
      for (int k = 0; k < 32; k++) begin
        seed = lfsr(seed);
        pr[k] = (i == 0) ? 3'h3 : seed[2:0];
      end
      ackWait <= {1'b0, seed[6:4]};
      wr(`OFS_ENABLE_BASE, en[15:0]);
      wr(`OFS_ENABLE_BASE + 8'h04, en[31:16]);
      for (int k = 0; k < 8; k++)
        wr(`OFS_PRIORITY_BASE + 8'(4 * k),
          {1'b0, pr[4*k+3], 1'b0, pr[4*k+2], 1'b0, pr[4*k+1], 1'b0, pr[4*k]});
      wr(`OFS_CPU_STATUS, {8'h00, cl, 5'h00});
      pulse(fl, 5'h0);
      ex = win();
      chk(irqRequest, ex[11]);
      rc(`OFS_FLAG_BASE + 8'h04, fl[31:16]);
      rc(`OFS_ENABLE_BASE, en[15:0]);
      if (ex[11]) begin
        chk(irqVector, ex[10:4]);
        chk(irqLevel, ex[3:0]);
        rc(`OFS_PENDING_VECTOR, {4'h0, ex[3:0], 1'b0, ex[10:4]});
      end
      clr;
    end
    wr(`OFS_ENABLE_BASE, 16'h0002);
    wr(`OFS_ENABLE_BASE + 8'h04, 16'h0);
    wr(`OFS_PRIORITY_BASE, 16'h0050);
    wr(`OFS_CPU_STATUS, 16'h0);
    pulse(32'h2, 5'h0);
    cpu(1'b1, 4'h0);
    rc(`OFS_CPU_STATUS, 16'h00a0);
    chk(irqRequest, 1'b0);
    cpu(1'b0, 4'h8);
    chk(irqRequest, 1'b0);
    cpu(1'b0, 4'h0);
    wr(`OFS_GLOBAL_CTRL_ONE, 16'h8000);
    cpu(1'b1, 4'h0);
    rc(`OFS_CPU_STATUS, 16'h00e0);
    wr(`OFS_GLOBAL_CTRL_ONE, 16'h0);
    clr;
    pulse(32'h0, 5'b00101);
    chk(irqVector, 7'd2);
    chk(irqLevel, 4'd13);
    rc(`OFS_GLOBAL_CTRL_ONE, 16'h0058);
    cpu(1'b1, 4'h0);
    rc(`OFS_CORE_CONTROL, 16'h0008);
    wr(`OFS_CORE_CONTROL, 16'h0);
    rc(`OFS_CORE_CONTROL, 16'h0008);
    wr(`OFS_GLOBAL_CTRL_ONE, 16'h0);
    cpu(1'b0, 4'h0);
    chk(irqRequest, 1'b0);
    wr(`OFS_GLOBAL_CTRL_TWO, 16'h8007);
    chk(useAltTable, 1'b1);
    rc(`OFS_GLOBAL_CTRL_TWO, 16'h8007);
    pins(3'b111);
    rc(`OFS_FLAG_BASE, 16'h0);
    pins(3'b000);
    rc(`OFS_FLAG_BASE + 8'h04, 16'h2010);
    clr;
    wr(`OFS_GLOBAL_CTRL_TWO, 16'h0);
    pins(3'b111);
    rc(`OFS_FLAG_BASE, 16'h0001);
    wstrb <= 4'h1;
    wr(`OFS_ENABLE_BASE, 16'hffff);
    wstrb <= 4'h3;
    rc(`OFS_ENABLE_BASE, 16'h00ff);
    report_and_stop;
  end
endmodule : tb_vectored_priority_interrupt_ctrl

// file: hw/intc_defs.svh
// Offsets, field positions, reset values and sizes of the interrupt controller
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_GLOBAL_CTRL_ONE 8'h00
`define OFS_GLOBAL_CTRL_TWO 8'h04
`define OFS_FLAG_BASE 8'h08
`define OFS_ENABLE_BASE 8'h10
`define OFS_PRIORITY_BASE 8'h18
`define OFS_PENDING_VECTOR 8'h38
`define OFS_CPU_STATUS 8'h3c
`define OFS_CORE_CONTROL 8'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_NESTING_DISABLE 15
`define BIT_ALT_TABLE 15
`define POS_CPU_LEVEL 5
`define BIT_TOP_LEVEL 3
`define MASK_CTRL_ONE 16'h805e
`define MASK_CTRL_TWO 16'h8007
`define MASK_STATUS_KEEP 16'h010f
`define POS_PENDING_LEVEL 8

// ****************************************************************
// Sizes, reset values and fixed figures
// ****************************************************************
`define NUM_SOURCES 32
`define FIRST_USER_VECTOR 7'h08
`define TRAP_TOP_LEVEL 5'h0f
`define RESET_WORD 16'h0000
`define EXT_PIN_ZERO_IDX 0
`define EXT_PIN_ONE_IDX 20
`define EXT_PIN_TWO_IDX 29

`endif

// file: hw/intc_pkg.sv
// Types shared by the interrupt controller files
package intc_pkg;
  typedef logic [15:0] word_type;
  typedef logic [6:0] vector_type;
  typedef logic [3:0] level_type;
  typedef logic [2:0] prio_type;
  typedef logic [31:0] axi_data_type;
  typedef logic [7:0] axi_addr_type;
endpackage : intc_pkg

// file: hw/pin_edge_detect.sv
// Synchroniser and polarity-selected edge detector for one external pin
`timescale 1ns/1ps
module pin_edge_detect (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pin and polarity
  input wire logic pinIn,
  input wire logic fallingEdge,
  // Detected edge, one-cycle pulse
  output logic edgeSeen
);
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Level only moves once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      level_reg <= 1'b0;
      edgeSeen <= 1'b0;
    end else begin
      edgeSeen <= 1'b0;
      if (sync2_reg == sync3_reg && sync3_reg != level_reg) begin
        level_reg <= sync3_reg;
        edgeSeen <= fallingEdge ? ~sync3_reg : sync3_reg;
      end
    end
  end
endmodule : pin_edge_detect

// file: hw/vectored_priority_interrupt_ctrl.sv
// Vectored priority interrupt controller with AXI4-Lite register access
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "intc_defs.svh"
module vectored_priority_interrupt_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire intc_pkg::axi_addr_type awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire intc_pkg::axi_data_type wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire intc_pkg::axi_addr_type araddr,
  output logic rvalid,
  input wire logic rready,
  output intc_pkg::axi_data_type rdata,
  output logic [1:0] rresp,
  // Interrupt sources
  input wire logic [`NUM_SOURCES-1:0] sourcePulse,
  input wire logic [2:0] extPins,
  input wire logic [4:0] trapPulse,
  // CPU side
  input wire logic cpuAck,
  input wire logic cpuReturn,
  input wire intc_pkg::level_type returnLevel,
  output logic irqRequest,
  output intc_pkg::vector_type irqVector,
  output intc_pkg::level_type irqLevel,
  output logic useAltTable,
  output logic nestingOff
);
  import intc_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  word_type ctrlOne_reg;
  word_type ctrlTwo_reg;
  logic [`NUM_SOURCES-1:0] flag_reg;
  logic [`NUM_SOURCES-1:0] enable_reg;
  prio_type prio_reg [`NUM_SOURCES];
  vector_type pendVector_reg;
  level_type pendLevel_reg;
  prio_type cpuLevel_reg;
  logic topLevel_reg;
  word_type statusKeep_reg;
  logic [2:0] extEdge;
  logic [`NUM_SOURCES-1:0] setVec;
  logic [4:0] trapSet;
  logic awHeld_reg;
  logic wHeld_reg;
  axi_addr_type wAddr_reg;
  axi_data_type wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic wMapped;
  word_type wWord;
  word_type rWord;
  logic rMapped;
  level_type cpuLevel;
  logic found;
  vector_type bestVector;
  level_type bestLevel;
  logic trapFound;
  vector_type trapVector;

  // ****************************************************************
  // External pins and event gathering
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      pin_edge_detect u_edge (
        .mclk(mclk),
        .reset(reset),
        .pinIn(extPins[gi]),
        .fallingEdge(ctrlTwo_reg[gi]),
        .edgeSeen(extEdge[gi])
      );
    end
  endgenerate

  // pins land on their vector-order flag bits
  always_comb begin
    setVec = sourcePulse;
    setVec[`EXT_PIN_ZERO_IDX] = sourcePulse[`EXT_PIN_ZERO_IDX] | extEdge[0];
    setVec[`EXT_PIN_ONE_IDX] = sourcePulse[`EXT_PIN_ONE_IDX] | extEdge[1];
    setVec[`EXT_PIN_TWO_IDX] = sourcePulse[`EXT_PIN_TWO_IDX] | extEdge[2];
  end

  // Trap pulses: divide by zero, oscillator, address, stack, math
  assign trapSet = trapPulse;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign wWord = {wStrb_reg[1] ? wData_reg[15:8] : 8'h00,
                  wStrb_reg[0] ? wData_reg[7:0] : 8'h00};

  // Address and data captured in either order
  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= !awHeld_reg && !(awvalid && awready);
      wready <= !wHeld_reg && !(wvalid && wready);
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        wAddr_reg <= awaddr;
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Decode of mapped write addresses
  always_comb begin
    wMapped = 1'b0;
    if (wAddr_reg[1:0] == 2'b00 && wAddr_reg <= `OFS_CORE_CONTROL) begin
      wMapped = 1'b1;
    end
  end

  // Write response, error on unmapped offset
  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wMapped ? 2'b00 : 2'b10;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // global controls, trap flags sticky with set winning
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlOne_reg <= `RESET_WORD;
      ctrlTwo_reg <= `RESET_WORD;
    end else begin
      if (doWrite && wAddr_reg == `OFS_GLOBAL_CTRL_ONE) begin
        ctrlOne_reg <= wWord & `MASK_CTRL_ONE;
      end
      if (doWrite && wAddr_reg == `OFS_GLOBAL_CTRL_TWO) begin
        ctrlTwo_reg <= wWord & `MASK_CTRL_TWO;
      end
      // trap status bits set by hardware; address at bit 3, stack at bit 2
      for (int t = 1; t < 5; t++) begin
        if (trapSet[t]) begin
          ctrlOne_reg[(t == 2) ? 3 : (t == 3) ? 2 : t] <= 1'b1;
        end
      end
      if (trapSet[0]) begin
        ctrlOne_reg[6] <= 1'b1;
        ctrlOne_reg[4] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Flags, enables and priorities
  // ****************************************************************
  // flags set by sources, software write, set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_reg <= '0;
    end else begin
      if (doWrite && wAddr_reg == `OFS_FLAG_BASE) begin
        flag_reg[15:0] <= wWord;
      end
      if (doWrite && wAddr_reg == `OFS_FLAG_BASE + 8'h04) begin
        flag_reg[31:16] <= wWord;
      end
      for (int s = 0; s < `NUM_SOURCES; s++) begin
        if (setVec[s]) begin
          flag_reg[s] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_reg <= '0;
    end else begin
      if (doWrite && wAddr_reg == `OFS_ENABLE_BASE) begin
        enable_reg[15:0] <= wWord;
      end
      if (doWrite && wAddr_reg == `OFS_ENABLE_BASE + 8'h04) begin
        enable_reg[31:16] <= wWord;
      end
    end
  end

  // four three-bit priorities per register, low source first
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int p = 0; p < `NUM_SOURCES; p++) begin
        prio_reg[p] <= 3'h0;
      end
    end else begin
      for (int p = 0; p < `NUM_SOURCES; p++) begin
        if (doWrite && wAddr_reg == `OFS_PRIORITY_BASE + 8'((p / 4) * 4)) begin
          prio_reg[p] <= wWord[(p % 4) * 4 +: 3];
        end
      end
    end
  end

  // ****************************************************************
  // CPU status and core control
  // ****************************************************************
  // four-bit CPU level from top bit and status field
  assign cpuLevel = {topLevel_reg, cpuLevel_reg};

  // level field writable unless nesting disabled
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpuLevel_reg <= 3'h0;
      statusKeep_reg <= `RESET_WORD;
    end else begin
      if (doWrite && wAddr_reg == `OFS_CPU_STATUS) begin
        statusKeep_reg <= wWord & `MASK_STATUS_KEEP;
        if (!ctrlOne_reg[`BIT_NESTING_DISABLE]) begin
          cpuLevel_reg <= wWord[`POS_CPU_LEVEL +: 3];
        end
      end
      // entry raises level, blocks user-source nesting when disabled
      if (cpuAck && irqRequest) begin
        cpuLevel_reg <= ctrlOne_reg[`BIT_NESTING_DISABLE] ? 3'h7 : irqLevel[2:0];
      end else if (cpuReturn) begin
        cpuLevel_reg <= returnLevel[2:0];
      end
    end
  end

  // top bit has no software write path
  always_ff @(posedge mclk) begin
    if (reset) begin
      topLevel_reg <= 1'b0;
    end else if (cpuAck && irqRequest) begin
      topLevel_reg <= irqLevel[3];
    end else if (cpuReturn) begin
      topLevel_reg <= returnLevel[3];
    end
  end

  // ****************************************************************
  // Priority resolution
  // ****************************************************************
  // highest enabled pending priority, strict compare keeps lower index
  always_comb begin
    found = 1'b0;
    bestVector = 7'h00;
    bestLevel = 4'h0;
    for (int s = 0; s < `NUM_SOURCES; s++) begin
      if (flag_reg[s] && enable_reg[s] && {1'b0, prio_reg[s]} > bestLevel) begin
        found = 1'b1;
        bestVector = `FIRST_USER_VECTOR + 7'(s);
        bestLevel = {1'b0, prio_reg[s]};
      end
    end
    // user level never exceeds 7, so 111 or top bit blocks it
    if (bestLevel <= cpuLevel) begin
      found = 1'b0;
    end
  end

  // Traps: lower vector wins, level fifteen minus vector
  always_comb begin
    trapFound = 1'b0;
    trapVector = 7'h00;
    for (int t = 4; t > 0; t--) begin
      // Vector t read from its status bit position
      if (ctrlOne_reg[(t == 2) ? 3 : (t == 3) ? 2 : t]) begin
        trapFound = 1'b1;
        trapVector = 7'(t);
      end
    end
    if ({1'b0, `TRAP_TOP_LEVEL} - {1'b0, 4'(trapVector)} <= {1'b0, cpuLevel}) begin
      trapFound = 1'b0;
    end
  end

  // latch vector and level of the presented interrupt
  always_ff @(posedge mclk) begin
    if (reset) begin
      pendVector_reg <= 7'h00;
      pendLevel_reg <= 4'h0;
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= trapFound || found;
      if (trapFound) begin
        pendVector_reg <= trapVector;
        pendLevel_reg <= 4'(`TRAP_TOP_LEVEL - 5'(trapVector));
      end else if (found) begin
        pendVector_reg <= bestVector;
        pendLevel_reg <= bestLevel;
      end
    end
  end

  assign irqVector = pendVector_reg;
  assign irqLevel = pendLevel_reg;

  // table select and nesting state driven out from registers
  assign useAltTable = ctrlTwo_reg[`BIT_ALT_TABLE];
  assign nestingOff = ctrlOne_reg[`BIT_NESTING_DISABLE];

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rWord = 16'h0000;
    rMapped = 1'b1;
    if (araddr == `OFS_GLOBAL_CTRL_ONE) begin
      rWord = ctrlOne_reg;
    end else if (araddr == `OFS_GLOBAL_CTRL_TWO) begin
      rWord = ctrlTwo_reg;
    end else if (araddr == `OFS_FLAG_BASE) begin
      rWord = flag_reg[15:0];
    end else if (araddr == `OFS_FLAG_BASE + 8'h04) begin
      rWord = flag_reg[31:16];
    end else if (araddr == `OFS_ENABLE_BASE) begin
      rWord = enable_reg[15:0];
    end else if (araddr == `OFS_ENABLE_BASE + 8'h04) begin
      rWord = enable_reg[31:16];
    end else if (araddr >= `OFS_PRIORITY_BASE && araddr < `OFS_PENDING_VECTOR
                 && araddr[1:0] == 2'b00) begin
      for (int q = 0; q < 4; q++) begin
        rWord[q * 4 +: 3] = prio_reg[((araddr - `OFS_PRIORITY_BASE) >> 2) * 4 + q];
      end
    end else if (araddr == `OFS_PENDING_VECTOR) begin
      rWord = {4'h0, pendLevel_reg, 1'b0, pendVector_reg};
    end else if (araddr == `OFS_CPU_STATUS) begin
      rWord = statusKeep_reg | {8'h00, cpuLevel_reg, 5'h00};
    end else if (araddr == `OFS_CORE_CONTROL) begin
      rWord = {12'h000, topLevel_reg, 3'h0};
    end else begin
      rMapped = 1'b0;
    end
  end

  // Read address taken when no data waits
  always_ff @(posedge mclk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= {16'h0000, rWord};
        rresp <= rMapped ? 2'b00 : 2'b10;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : vectored_priority_interrupt_ctrl
